// [cws_pkg.sv]
// package of constants and types for the cache way and writeback side-band block
// How it works
// - way output high selects way one
// - exclusive_allowed high exclusive, low shared
// - write to exclusive or modified line allows
// - read to modified line allows exclusive
// - all other processor cycles drive low
// - processor exclusive only when own line exclusive or modified
// - indication valid at next address or ready
// - two-line sector: line select picks line
// - one-line sector holds line select low
// - snoop: line select shows buffer hit
// - writeback kind high snoop, low replacement
// - select and kind pins carry straps
// - load enable two clocks for two-line replacement, else one
package cws_pkg;
    // line states of the directory
    typedef enum logic [1:0] {
        CWS_INVALID,
        CWS_SHARED,
        CWS_EXCLUSIVE,
        CWS_MODIFIED
    } cws_line_t;

    // writeback kinds
    typedef enum logic [1:0] {
        CWS_WB_NONE,
        CWS_WB_REPLACE,
        CWS_WB_SNOOP
    } cws_wbreq_t;

    localparam logic [1:0] CWS_LOAD_CLKS_TWO = 2'h2;
    localparam logic [1:0] CWS_LOAD_CLKS_ONE = 2'h1;
    localparam logic CWS_RESET_WAY = 1'h0;
    localparam logic CWS_RESET_EXCL = 1'h0;
    localparam logic CWS_RESET_LOAD_N = 1'h1;
    localparam logic CWS_STRAP_DEFAULT_N = 1'h1;
    localparam logic [1:0] CWS_STRAP_SETTLE = 2'h2;
endpackage : cws_pkg

// [cws_sideband.sv]
// side-band way, exclusivity and writeback outputs toward the data sram and processor
`timescale 1ns/1ps
module cws_sideband (
    // clock and control
    input wire logic sysClk,
    input wire logic reset,
    input wire logic clkEn,
    // configuration straps shared with output pins
    input wire logic twoLineSectorStrapIn_n,
    input wire logic lineRatioStrap0In,
    output logic strapPinsDriveEn,
    // processor cycle from directory
    input wire logic cycleValid,
    input wire logic cycleWrite,
    input wire logic cycleWay,
    input wire cws_pkg::cws_line_t cycleLineState,
    input wire logic nextAddressStrobe_n,
    input wire logic burstReady_n,
    // strobe requests from directory
    input wire logic arrayWriteReq,
    input wire logic memoryCycleReq,
    // writeback requests
    input wire cws_pkg::cws_wbreq_t wbReq,
    input wire logic wbWay,
    input wire logic snoopHitReplaceBuf,
    output logic wbBusy,
    // outputs to sram and processor
    output logic way,
    output logic exclusiveAllowed,
    output logic arrayWriteStrobe_n,
    output logic memoryCycleStrobe_n,
    output logic wbufLoadEnable_n,
    output logic wbackLineSelect,
    output logic wbackKind,
    output logic twoLineSectorMode
);
    import cws_pkg::*;

    cws_wb_if wbBus ();

    // strap synchronisers and capture
    logic [1:0] secSync_q;
    logic [1:0] secSync_d;
    logic [1:0] lrSync_q;
    logic [1:0] lrSync_d;
    logic [1:0] strapAge_q;
    logic [1:0] strapAge_d;
    logic twoLine_q;
    logic twoLine_d;
    logic strapCaught_q;
    logic strapCaught_d;

    // registered outputs
    logic way_q;
    logic way_d;
    logic excl_q;
    logic excl_d;
    logic arr_q;
    logic arr_d;
    logic memory_cycle_strobe_n_q;
    logic memory_cycle_strobe_n_d;
    logic load_q;
    logic load_d;
    logic wba_q;
    logic wba_d;
    logic kind_q;
    logic kind_d;
    logic cycOpen_q;
    logic cycOpen_d;
    logic snoopWb_q;
    logic snoopWb_d;
    logic snoopHit_q;
    logic snoopHit_d;
    logic wbWayHold_q;
    logic wbWayHold_d;

    // decide whether the processor may hold the line exclusive
    function automatic logic exclDecide(input logic isWrite, input cws_line_t st);
        if (isWrite) begin
            exclDecide = (st == CWS_EXCLUSIVE) || (st == CWS_MODIFIED);
        end else begin
            exclDecide = (st == CWS_MODIFIED);
        end
    endfunction : exclDecide

    // true for a snoop writeback request
    function automatic logic isSnoop(input cws_wbreq_t req);
        isSnoop = (req == CWS_WB_SNOOP);
    endfunction : isSnoop

    // writeback load sequencer
    cws_wb_seq u_seq (
        .sysClk(sysClk),
        .reset(reset),
        .clkEn(clkEn),
        .wb(wbBus.seq)
    );

    // requests are taken only while no load is in progress
    assign wbBus.start = (wbReq != CWS_WB_NONE) && !wbBus.busy;
    assign wbBus.twoLine = twoLine_q && (wbReq == CWS_WB_REPLACE);

    // strap capture after reset release, while pins are not driven
    always_comb begin
        secSync_d = {secSync_q[0], twoLineSectorStrapIn_n};
        lrSync_d = {lrSync_q[0], lineRatioStrap0In};
        strapCaught_d = strapCaught_q;
        strapAge_d = strapAge_q;
        twoLine_d = twoLine_q;
        // wait until the synchroniser holds the pin level before taking it
        if (!strapCaught_q) begin
            if (strapAge_q == CWS_STRAP_SETTLE) begin
                twoLine_d = !secSync_q[1];
                strapCaught_d = 1'b1;
            end else begin
                strapAge_d = strapAge_q + 2'h1;
            end
        end
    end

    always_ff @(posedge sysClk) begin
        if (reset) begin
            secSync_q <= {2{CWS_STRAP_DEFAULT_N}};
            lrSync_q <= 2'h0;
            strapAge_q <= 2'h0;
            twoLine_q <= 1'b0;
            strapCaught_q <= 1'b0;
        end else if (clkEn) begin
            secSync_q <= secSync_d;
            lrSync_q <= lrSync_d;
            strapAge_q <= strapAge_d;
            twoLine_q <= twoLine_d;
            strapCaught_q <= strapCaught_d;
        end
    end

    // next values of the side-band outputs
    always_comb begin
        way_d = way_q;
        excl_d = excl_q;
        arr_d = 1'b1;
        memory_cycle_strobe_n_d = 1'b1;
        load_d = !wbBus.loadActive;
        wba_d = wba_q;
        kind_d = kind_q;
        cycOpen_d = cycOpen_q;
        snoopWb_d = snoopWb_q;
        snoopHit_d = snoopHit_q;
        wbWayHold_d = wbWayHold_q;
        if (wbBus.start) begin
            snoopWb_d = isSnoop(wbReq);
            snoopHit_d = snoopHitReplaceBuf;
            wbWayHold_d = wbWay;
        end
        if (cycleValid) begin
            way_d = cycleWay;
            excl_d = exclDecide(cycleWrite, cycleLineState);
            cycOpen_d = 1'b1;
            arr_d = !arrayWriteReq;
            memory_cycle_strobe_n_d = !memoryCycleReq;
        end
        if (cycOpen_q && (!nextAddressStrobe_n || !burstReady_n)) begin
            cycOpen_d = cycleValid;
        end
        if (wbBus.start) begin
            way_d = wbWay;
            kind_d = isSnoop(wbReq);
            if (isSnoop(wbReq)) begin
                wba_d = snoopHitReplaceBuf;
            end else begin
                wba_d = 1'b0;
            end
        end else if (wbBus.busy) begin
            way_d = wbWayHold_q;
            kind_d = snoopWb_q;
            if (snoopWb_q) begin
                wba_d = snoopHit_q;
            end else begin
                wba_d = twoLine_q && wbBus.secondLine;
            end
        end
    end

    // side-band output registers
    always_ff @(posedge sysClk) begin
        if (reset) begin
            way_q <= CWS_RESET_WAY;
            excl_q <= CWS_RESET_EXCL;
            arr_q <= 1'b1;
            memory_cycle_strobe_n_q <= 1'b1;
            load_q <= CWS_RESET_LOAD_N;
            wba_q <= 1'b0;
            kind_q <= 1'b0;
            cycOpen_q <= 1'b0;
            snoopWb_q <= 1'b0;
            snoopHit_q <= 1'b0;
            wbWayHold_q <= 1'b0;
        end else if (clkEn) begin
            way_q <= way_d;
            excl_q <= excl_d;
            arr_q <= arr_d;
            memory_cycle_strobe_n_q <= memory_cycle_strobe_n_d;
            load_q <= load_d;
            wba_q <= wba_d;
            kind_q <= kind_d;
            cycOpen_q <= cycOpen_d;
            snoopWb_q <= snoopWb_d;
            snoopHit_q <= snoopHit_d;
            wbWayHold_q <= wbWayHold_d;
        end
    end

    // way is set in the same edge as the matching strobe
    assign way = way_q;
    assign exclusiveAllowed = excl_q;
    assign arrayWriteStrobe_n = arr_q;
    assign memoryCycleStrobe_n = memory_cycle_strobe_n_q;
    assign wbufLoadEnable_n = load_q;
    assign wbackLineSelect = wba_q;
    assign wbackKind = kind_q;
    assign twoLineSectorMode = twoLine_q;
    assign strapPinsDriveEn = strapCaught_q;
    assign wbBusy = wbBus.busy;
endmodule : cws_sideband

// [cws_sideband_properties.sv]
// checker of the side-band output timing
`timescale 1ns/1ps
module cws_sideband_properties (
    // clock and reset
    input wire logic sysClk,
    input wire logic reset,
    // cycle and writeback inputs
    input wire logic cycleValid,
    input wire logic cycleWrite,
    input wire logic cycleWay,
    input wire logic arrayWriteReq,
    input wire cws_pkg::cws_line_t cycleLineState,
    input wire cws_pkg::cws_wbreq_t wbReq,
    input wire logic wbWay,
    input wire logic snoopHitReplaceBuf,
    input wire logic wbBusy,
    // outputs
    input wire logic way,
    input wire logic exclusiveAllowed,
    input wire logic arrayWriteStrobe_n,
    input wire logic wbufLoadEnable_n,
    input wire logic wbackLineSelect,
    input wire logic wbackKind,
    input wire logic twoLineSectorMode
);
    import cws_pkg::*;
    default clocking @(posedge sysClk);
    endclocking
    default disable iff (reset);
    logic cycGo, wbGo, exclExp;
    assign cycGo = cycleValid && wbReq == CWS_WB_NONE && !wbBusy;
    assign wbGo = wbReq != CWS_WB_NONE && !wbBusy;
    assign exclExp = cycleWrite ? cycleLineState[1] : cycleLineState == CWS_MODIFIED;
    a_way_follows_cycle: assert property (cycGo |=> way == $past(cycleWay))
        else $error("way wrong");
    a_excl_granted: assert property (cycGo && exclExp |=> exclusiveAllowed)
        else $error("excl low");
    a_excl_refused: assert property (cycGo && !exclExp |=> !exclusiveAllowed)
        else $error("excl high");
    a_array_strobe: assert property (cycGo && arrayWriteReq |=> !arrayWriteStrobe_n)
        else $error("strobe");
    a_wb_way: assert property (wbGo |=> way == $past(wbWay))
        else $error("wb way");
    a_snoop_load: assert property (wbGo && wbReq == CWS_WB_SNOOP |=>
        !wbufLoadEnable_n && wbackKind && wbackLineSelect == $past(snoopHitReplaceBuf) ##1 wbufLoadEnable_n)
        else $error("snoop load");
    a_pair_load: assert property (wbGo && wbReq == CWS_WB_REPLACE && twoLineSectorMode |=>
        !wbufLoadEnable_n && !wbackLineSelect && !wbackKind ##1 !wbufLoadEnable_n && wbackLineSelect
        ##1 wbufLoadEnable_n) else $error("pair load");
    a_single_load: assert property (wbGo && wbReq == CWS_WB_REPLACE && !twoLineSectorMode |=>
        !wbufLoadEnable_n && !wbackLineSelect ##1 wbufLoadEnable_n) else $error("single load");
    c_pair: cover property (wbGo && twoLineSectorMode && wbReq == CWS_WB_REPLACE);
    c_snoop: cover property (wbGo && wbReq == CWS_WB_SNOOP && snoopHitReplaceBuf);
    c_excl: cover property (cycGo && exclExp);
endmodule : cws_sideband_properties
bind cws_sideband cws_sideband_properties u_props (.*);

// [cws_sideband_tb_top.sv]
// self-checking testbench of the side-band block
`timescale 1ns/1ps
module cws_sideband_tb_top;
    import cws_pkg::*;
    logic sysClk = 1'h0, reset = 1'h1, clkEn = 1'h1, twoLineSectorStrapIn_n = 1'h0, lineRatioStrap0In = 1'h0;
    logic cycleValid = 1'h0, cycleWrite = 1'h0, cycleWay = 1'h0, arrayWriteReq = 1'h0, memoryCycleReq = 1'h0;
    logic nextAddressStrobe_n = 1'h1, burstReady_n = 1'h1, wbWay = 1'h0, snoopHitReplaceBuf = 1'h0;
    cws_line_t cycleLineState = CWS_INVALID;
    cws_wbreq_t wbReq = CWS_WB_NONE;
    logic strapPinsDriveEn, wbBusy, way, exclusiveAllowed, arrayWriteStrobe_n, memoryCycleStrobe_n;
    logic wbufLoadEnable_n, wbackLineSelect, wbackKind, twoLineSectorMode, arrayWay, missWay, mruBit, snoopSel;
    logic [1:0] replSel;
    logic loadWay;
    int n_fail = 0, check_count = 0;
    cws_sideband DUT (.*);
    cws_sram_model u_sram (.*);
    initial begin
        forever #25 sysClk = ~sysClk;
    end
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'h1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task automatic do_reset(input logic strapN);
        @(posedge sysClk);
        twoLineSectorStrapIn_n <= strapN;
        reset <= 1'h1;
        repeat (2) @(posedge sysClk);
        reset <= 1'h0;
        repeat (4) @(posedge sysClk);
        #1;
        chk(twoLineSectorMode === !strapN && strapPinsDriveEn === 1'h1, "strap");
    endtask : do_reset
    task automatic t_cycles;
        for (int i = 0; i < 8; i++) begin
            @(posedge sysClk);
            {cycleValid, cycleWrite, cycleWay} <= {1'h1, i[2], i[0]};
            arrayWriteReq <= i[2] || i[1];
            memoryCycleReq <= !i[2] && !i[1];
            cycleLineState <= cws_line_t'(i[1:0]);
            @(posedge sysClk);
            {cycleValid, arrayWriteReq, memoryCycleReq} <= 3'h0;
            #1;
            chk(exclusiveAllowed === (i[2] ? i[1] : i[1:0] == 2'h3) && way === i[0], "cycle");
            @(posedge sysClk);
            #1;
            chk((i[2] || i[1] ? arrayWay : missWay) === i[0], "sram way");
            @(posedge sysClk);
            #1;
            chk(!(i[2] || i[1]) || mruBit === i[0], "recent way");
        end
    endtask : t_cycles
    task automatic t_writeback(input cws_wbreq_t kind, input logic hit, input logic twoLine);
        logic snp;
        snp = kind == CWS_WB_SNOOP;
        @(posedge sysClk);
        {wbReq, wbWay, snoopHitReplaceBuf} <= {kind, !hit, hit};
        @(posedge sysClk);
        wbReq <= CWS_WB_NONE;
        #1;
        chk(!wbufLoadEnable_n && wbackKind === snp && way === !hit, "load first");
        chk(wbackLineSelect === (snp && hit), "select first");
        chk(wbBusy === 1'h1, "busy");
        @(posedge sysClk);
        #1;
        if (!snp && twoLine) begin
            chk(!wbufLoadEnable_n && wbackLineSelect === 1'h1, "load second");
            @(posedge sysClk);
            #1;
        end
        chk(wbufLoadEnable_n === 1'h1 && wbBusy === 1'h0, "load end");
        chk(snp ? snoopSel === hit : replSel === (twoLine ? 2'h1 : 2'h2), "buffer");
        chk(loadWay === !hit, "load way");
    endtask : t_writeback
    initial begin
        do_reset(1'h0);
        t_cycles();
        t_writeback(CWS_WB_REPLACE, 1'h0, 1'h1);
        t_writeback(CWS_WB_SNOOP, 1'h1, 1'h1);
        t_writeback(CWS_WB_SNOOP, 1'h0, 1'h1);
        do_reset(1'h1);
        t_writeback(CWS_WB_REPLACE, 1'h1, 1'h0);
        end_sim();
    end
    initial begin
        repeat (2000) @(posedge sysClk);
        n_fail++;
        end_sim();
    end
endmodule : cws_sideband_tb_top

// [cws_sram_model.sv]
// data sram model capturing the side-band outputs
`timescale 1ns/1ps
module cws_sram_model (
    // side-band from controller
    input wire logic sysClk,
    input wire logic way,
    input wire logic arrayWriteStrobe_n,
    input wire logic memoryCycleStrobe_n,
    input wire logic wbufLoadEnable_n,
    input wire logic wbackLineSelect,
    input wire logic wbackKind,
    // captured values
    output logic arrayWay,
    output logic missWay,
    output logic mruBit,
    output logic snoopSel,
    output logic loadWay,
    output logic [1:0] replSel
);
    logic mruPend = 1'h0;
    always @(posedge sysClk) begin
        mruPend <= !arrayWriteStrobe_n;
        if (!arrayWriteStrobe_n) arrayWay <= way;
        if (mruPend) mruBit <= arrayWay;
        if (!memoryCycleStrobe_n) missWay <= way;
        if (!wbufLoadEnable_n) loadWay <= way;
        if (!wbufLoadEnable_n && wbackKind) snoopSel <= wbackLineSelect;
        if (!wbufLoadEnable_n && !wbackKind) replSel <= {replSel[0], wbackLineSelect};
    end
endmodule : cws_sram_model

// [cws_wb_if.sv]
// interface carrying the writeback sequencing between top and sequencer
`timescale 1ns/1ps
interface cws_wb_if;
    logic start;
    logic twoLine;
    logic busy;
    logic loadActive;
    logic secondLine;
    modport seq (
        input start,
        input twoLine,
        output busy,
        output loadActive,
        output secondLine
    );
    modport ctl (
        output start,
        output twoLine,
        input busy,
        input loadActive,
        input secondLine
    );
endinterface : cws_wb_if

// [cws_wb_seq.sv]
// writeback load enable sequencer
`timescale 1ns/1ps
module cws_wb_seq (
    // clock and control
    input wire logic sysClk,
    input wire logic reset,
    input wire logic clkEn,
    // sequencing
    cws_wb_if.seq wb
);
    import cws_pkg::*;

    logic [1:0] remain_q;
    logic [1:0] remain_d;

    always_comb begin
        remain_d = remain_q;
        if (remain_q != 2'h0) begin
            remain_d = remain_q - 2'h1;
        end else if (wb.start) begin
            remain_d = wb.twoLine ? CWS_LOAD_CLKS_TWO : CWS_LOAD_CLKS_ONE;
        end
    end

    always_ff @(posedge sysClk) begin
        if (reset) begin
            remain_q <= 2'h0;
        end else if (clkEn) begin
            remain_q <= remain_d;
        end
    end

    assign wb.busy = (remain_q != 2'h0);
    // load follows the count held after this edge, so it lines up with way, select and kind
    assign wb.loadActive = (remain_d != 2'h0);
    assign wb.secondLine = (remain_q == CWS_LOAD_CLKS_TWO);
endmodule : cws_wb_seq
